/* File: hdl/host_port_map.svh */
// Purpose: offsets, field positions and timing counts of the host memory port
// Assumes: 200 MHz processor clock
// Notes:   definitions only
`ifndef HOST_PORT_MAP_SVH
`define HOST_PORT_MAP_SVH
`define HP_CTRL_ADDR        14'h3fe0
`define HP_CTRL_RESET       16'h0000
`define HP_OVL_FLAG_BIT     15
`define HP_MEMSEL_BIT       14
`define HP_ADDR_MSB         13
`define HP_OVL_MSB          7
`define HP_MMR_BASE         14'h3fe0
`define HP_MODE_HOST_BOOT   3'h5
`define HP_MODE_SETTLE      2'h2
`define HP_PM_WORD_W        24
`endif

/* File: hdl/host_port_pkg.sv */
// Purpose: shared types for the host memory port
// Assumes: nothing
// Notes:   constants live in host_port_map.svh
package host_port_pkg;
    typedef struct packed {
        logic        memsel;
        logic [13:0] addr;
    } start_addr_t;

    typedef struct packed {
        logic        req;
        logic        we;
        logic        memsel;
        logic [13:0] addr;
        logic [23:0] wdata;
    } mem_req_t;

    typedef enum logic [3:0] {
        ST_IDLE = 4'b0001,
        ST_SYNC = 4'b0010,
        ST_ACC  = 4'b0100,
        ST_DONE = 4'b1000
    } port_state_t;
endpackage

/* File: hdl/strobe_sync.sv */
// Purpose: two-flop synchroniser for a group of asynchronous pin levels
// Assumes: one clock
// Notes:   first stage is read only by the second stage
`timescale 1ns/1ps
`default_nettype none
module strobe_sync #(
    parameter int W = 1
) (
    input  wire logic         mclk_i,
    input  wire logic         reset_i,
    input  wire logic [W-1:0] async_i,
    output logic      [W-1:0] sync_o
);
    logic [W-1:0] meta_q;

    always_ff @(posedge mclk_i or posedge reset_i) begin
        if (reset_i) begin
            meta_q <= '0;
            sync_o <= '0;
        end else begin
            meta_q <= async_i;
            sync_o <= meta_q;
        end
    end
endmodule
`default_nettype wire

/* File: hdl/host_memory_port.sv */
// Purpose: host port into on-chip program and data memory, multiplexed 16-bit bus
// Assumes: strobes are active-high levels from the pins (inverted outside if needed)
// Notes:   core memory is a simple one-cycle request/response port
//
// Functional notes
// [RULE1] host accesses never reach memory-mapped control registers
// [RULE2] latch with bit 15 set takes bits 7:0 as overlay; host zeroes 14:8
// [RULE3] latch with bit 15 clear takes 13:0 as address, bit 14 memory type
// [RULE4] 16-bit shared bus still moves 24-bit program words in two halves
// [RULE5] host strobes are asynchronous; core keeps running during writes
// [RULE6] latched address increments after every completed access
// [RULE7] host drives address and memory type only while acknowledge is asserted
// [RULE8] address captured on falling edge of address latch enable
// [RULE9] one cycle synchronising, one more performing the memory access
// [RULE10] host checks acknowledge before a transfer and after each one
// [RULE11] start address register mapped in data memory for the core
// [RULE12] host cannot read back the latched address; reads return memory
// [RULE13] mode pins C=1 B=0 A=1 at reset select boot through this port
// [RULE14] in that boot, execution waits for a host write to program word 0
// [RULE15] acknowledge drops while an access is pending, returns on completion
// [RULE16] host strobes pass two flip-flops before any logic uses them
`timescale 1ns/1ps
`default_nettype none
`include "host_port_map.svh"
module host_memory_port (
    input  wire logic        mclk_i,
    input  wire logic        reset_i,
    // host pins
    input  wire logic        port_select_i,
    input  wire logic        address_latch_enable_i,
    input  wire logic        host_read_strobe_i,
    input  wire logic        host_write_strobe_i,
    input  wire logic [15:0] host_addr_data_bus_i,
    output logic      [15:0] host_addr_data_bus_o,
    output logic             host_addr_data_bus_oe_o,
    output logic             host_acknowledge_o,
    // boot mode pins {c,b,a}
    input  wire logic [2:0]  boot_mode_i,
    // core register access to the start address register
    input  wire logic        core_reg_we_i,
    input  wire logic        core_reg_re_i,
    input  wire logic [13:0] core_reg_addr_i,
    input  wire logic [15:0] core_reg_wdata_i,
    output logic      [15:0] core_reg_rdata_o,
    // on-chip memory port
    output logic             mem_req_o,
    output logic             mem_we_o,
    output logic             mem_memsel_o,
    output logic      [13:0] mem_addr_o,
    output logic      [23:0] mem_wdata_o,
    input  wire logic [23:0] mem_rdata_i,
    output logic      [7:0]  overlay_selection_o,
    output logic             core_hold_o
);
    // ------------------------------------------------------------
    // synchronisers
    // ------------------------------------------------------------
    logic [3:0]  strobes_s;
    logic [15:0] bus_s;
    logic [2:0]  mode_s;
    strobe_sync #(.W(4)) u_sync_strb (
        .mclk_i  (mclk_i),
        .reset_i (reset_i),
        .async_i ({port_select_i, address_latch_enable_i,
                   host_read_strobe_i, host_write_strobe_i}),
        .sync_o  (strobes_s)
    ); // see [RULE5] see [RULE16]
    strobe_sync #(.W(16)) u_sync_bus (
        .mclk_i  (mclk_i),
        .reset_i (reset_i),
        .async_i (host_addr_data_bus_i),
        .sync_o  (bus_s)
    );
    strobe_sync #(.W(3)) u_sync_mode (
        .mclk_i  (mclk_i),
        .reset_i (reset_i),
        .async_i (boot_mode_i),
        .sync_o  (mode_s)
    );

    logic sel_s, ale_s, rd_s, wr_s;
    assign sel_s = strobes_s[3];
    assign ale_s = strobes_s[2];
    assign rd_s  = strobes_s[1];
    assign wr_s  = strobes_s[0];

    logic ale_prev_q, rd_prev_q, wr_prev_q;
    always_ff @(posedge mclk_i or posedge reset_i) begin
        if (reset_i) begin
            ale_prev_q <= 1'b0;
            rd_prev_q  <= 1'b0;
            wr_prev_q  <= 1'b0;
        end else begin
            ale_prev_q <= ale_s;
            rd_prev_q  <= rd_s & sel_s;
            wr_prev_q  <= wr_s & sel_s;
        end
    end
    logic ale_fall, rd_rise, wr_rise;
    assign ale_fall = ale_prev_q & ~ale_s & sel_s; // see [RULE8]
    assign rd_rise  = rd_s & sel_s & ~rd_prev_q;
    assign wr_rise  = wr_s & sel_s & ~wr_prev_q;

    // ------------------------------------------------------------
    // start address / overlay register
    // ------------------------------------------------------------
    host_port_pkg::start_addr_t start_q;
    logic [7:0] ovl_q;
    logic       half_q;   // 1 after the first half of a program word
    logic [15:0] hi_q;    // upper 16 bits of a program word being written
    logic       incr;
    logic       core_hit;
    assign core_hit = (core_reg_addr_i == `HP_CTRL_ADDR); // see [RULE11]

    always_ff @(posedge mclk_i or posedge reset_i) begin
        if (reset_i) begin
            start_q <= '0;
            ovl_q   <= 8'h00;
        end else if (ale_fall) begin
            if (bus_s[`HP_OVL_FLAG_BIT]) begin
                ovl_q <= bus_s[`HP_OVL_MSB:0]; // see [RULE2]
            end else begin
                start_q.memsel <= bus_s[`HP_MEMSEL_BIT]; // see [RULE3]
                start_q.addr   <= bus_s[`HP_ADDR_MSB:0];
            end
        end else if (core_reg_we_i && core_hit) begin
            if (core_reg_wdata_i[`HP_OVL_FLAG_BIT]) begin
                ovl_q <= core_reg_wdata_i[`HP_OVL_MSB:0];
            end else begin
                start_q.memsel <= core_reg_wdata_i[`HP_MEMSEL_BIT];
                start_q.addr   <= core_reg_wdata_i[`HP_ADDR_MSB:0];
            end
        end else if (incr) begin
            start_q.addr <= start_q.addr + 14'h0001; // see [RULE6]
        end
    end

    always_ff @(posedge mclk_i or posedge reset_i) begin
        if (reset_i) begin
            core_reg_rdata_o <= `HP_CTRL_RESET;
        end else if (core_reg_re_i && core_hit) begin
            core_reg_rdata_o <= {1'b0, start_q.memsel, start_q.addr};
        end else begin
            core_reg_rdata_o <= 16'h0000;
        end
    end

    // ------------------------------------------------------------
    // access sequencer
    // ------------------------------------------------------------
    host_port_pkg::port_state_t state_q;
    logic pend_we_q;
    logic [15:0] wdata_q;
    logic blocked;
    // data-space control registers sit at the top of data memory
    assign blocked = ~start_q.memsel && (start_q.addr >= `HP_MMR_BASE); // see [RULE1]

    always_ff @(posedge mclk_i or posedge reset_i) begin
        if (reset_i) begin
            state_q   <= host_port_pkg::ST_IDLE;
            pend_we_q <= 1'b0;
            wdata_q   <= 16'h0000;
        end else begin
            case (state_q)
                host_port_pkg::ST_IDLE: begin
                    if (rd_rise || wr_rise) begin
                        pend_we_q <= wr_rise;
                        wdata_q   <= bus_s;
                        state_q   <= host_port_pkg::ST_SYNC; // see [RULE9]
                    end
                end
                host_port_pkg::ST_SYNC: state_q <= host_port_pkg::ST_ACC;
                host_port_pkg::ST_ACC:  state_q <= host_port_pkg::ST_DONE;
                host_port_pkg::ST_DONE: state_q <= host_port_pkg::ST_IDLE;
                default:                state_q <= host_port_pkg::ST_IDLE;
            endcase
        end
    end

    // program words move as upper 16 bits then lower 8 bits; address steps after both
    logic last_half;
    assign last_half = ~start_q.memsel | half_q; // see [RULE4]
    assign incr = (state_q == host_port_pkg::ST_ACC) && last_half;

    always_ff @(posedge mclk_i or posedge reset_i) begin
        if (reset_i) begin
            half_q <= 1'b0;
            hi_q   <= 16'h0000;
        end else if (ale_fall) begin
            half_q <= 1'b0;
        end else if (state_q == host_port_pkg::ST_ACC && start_q.memsel) begin
            half_q <= ~half_q;
            if (!half_q) begin
                hi_q <= wdata_q;
            end
        end
    end

    always_ff @(posedge mclk_i or posedge reset_i) begin
        if (reset_i) begin
            mem_req_o    <= 1'b0;
            mem_we_o     <= 1'b0;
            mem_memsel_o <= 1'b0;
            mem_addr_o   <= 14'h0000;
            mem_wdata_o  <= 24'h000000;
        end else begin
            // a pm write only commits once both halves have arrived
            mem_req_o    <= (state_q == host_port_pkg::ST_SYNC) && !blocked &&
                            (!pend_we_q || last_half || !start_q.memsel);
            mem_we_o     <= pend_we_q && (state_q == host_port_pkg::ST_SYNC);
            mem_memsel_o <= start_q.memsel;
            mem_addr_o   <= start_q.addr;
            mem_wdata_o  <= start_q.memsel ? {hi_q, wdata_q[7:0]} : {8'h00, wdata_q};
        end
    end

    // read data: host sees memory only, never the latched address
    always_ff @(posedge mclk_i or posedge reset_i) begin
        if (reset_i) begin
            host_addr_data_bus_o <= 16'h0000;
        end else if (state_q == host_port_pkg::ST_DONE && !pend_we_q) begin
            if (!start_q.memsel) begin
                host_addr_data_bus_o <= mem_rdata_i[15:0]; // see [RULE12]
            end else if (half_q) begin
                host_addr_data_bus_o <= mem_rdata_i[23:8];
            end else begin
                host_addr_data_bus_o <= {8'h00, mem_rdata_i[7:0]};
            end
        end
    end

    always_ff @(posedge mclk_i or posedge reset_i) begin
        if (reset_i) begin
            host_addr_data_bus_oe_o <= 1'b0;
        end else begin
            host_addr_data_bus_oe_o <= sel_s & rd_s & (state_q == host_port_pkg::ST_IDLE);
        end
    end

    always_ff @(posedge mclk_i or posedge reset_i) begin
        if (reset_i) begin
            host_acknowledge_o <= 1'b1;
        end else begin
            host_acknowledge_o <= (state_q == host_port_pkg::ST_IDLE) &&
                                  !rd_rise && !wr_rise; // see [RULE15] see [RULE10]
        end
    end

    // ------------------------------------------------------------
    // boot through the host port
    // ------------------------------------------------------------
    logic [1:0] mode_wait_q;
    logic       mode_taken_q;
    // the mode pins only hold their true level once through the synchroniser
    always_ff @(posedge mclk_i or posedge reset_i) begin
        if (reset_i) begin
            mode_wait_q  <= 2'h0;
            mode_taken_q <= 1'b0;
            core_hold_o  <= 1'b0;
        end else if (!mode_taken_q) begin
            if (mode_wait_q == `HP_MODE_SETTLE) begin
                mode_taken_q <= 1'b1;
                core_hold_o  <= (mode_s == `HP_MODE_HOST_BOOT); // see [RULE13]
            end else begin
                mode_wait_q <= mode_wait_q + 2'h1;
            end
        end else if (mem_req_o && mem_we_o && mem_memsel_o && mem_addr_o == 14'h0000) begin
            core_hold_o <= 1'b0; // see [RULE14]
        end
    end

    assign overlay_selection_o = ovl_q;

    // ------------------------------------------------------------
    // assertions
    // ------------------------------------------------------------
    AST_SYNC_THEN_ACC: assert property (@(posedge mclk_i) disable iff (reset_i)
        state_q == host_port_pkg::ST_SYNC |=> state_q == host_port_pkg::ST_ACC) // see [RULE9]
        else $error("sync not followed by access");
    AST_ACK_LOW_PENDING: assert property (@(posedge mclk_i) disable iff (reset_i)
        (state_q != host_port_pkg::ST_IDLE) |=> !host_acknowledge_o) // see [RULE15]
        else $error("acknowledge high during access");
    AST_INCR: assert property (@(posedge mclk_i) disable iff (reset_i)
        incr && !ale_fall && !(core_reg_we_i && core_hit)
        |=> start_q.addr == $past(start_q.addr) + 14'h0001) // see [RULE6]
        else $error("address did not increment");
    AST_NO_MMR: assert property (@(posedge mclk_i) disable iff (reset_i)
        mem_req_o |-> (mem_memsel_o || mem_addr_o < `HP_MMR_BASE)) // see [RULE1]
        else $error("control register reached from host");
    AST_LATCH_ADDR: assert property (@(posedge mclk_i) disable iff (reset_i)
        ale_fall && !bus_s[15] |=> start_q.addr == $past(bus_s[13:0])) // see [RULE3]
        else $error("start address not latched");
    AST_LATCH_OVL: assert property (@(posedge mclk_i) disable iff (reset_i)
        ale_fall && bus_s[15] |=> ovl_q == $past(bus_s[7:0])) // see [RULE2]
        else $error("overlay not latched");
    AST_REQ_TIMING: assert property (@(posedge mclk_i) disable iff (reset_i)
        (state_q == host_port_pkg::ST_IDLE) && wr_rise && !blocked
        |-> ##2 (mem_req_o || start_q.memsel)) // see [RULE9]
        else $error("memory access not two cycles after strobe");
    AST_HOLD_RELEASE: assert property (@(posedge mclk_i) disable iff (reset_i)
        mode_taken_q && mem_req_o && mem_we_o && mem_memsel_o && mem_addr_o == 14'h0000
        |=> !core_hold_o) // see [RULE14]
        else $error("hold not released by write to word 0");
    AST_REG_ONLY_CORE: assert property (@(posedge mclk_i) disable iff (reset_i)
        !core_reg_re_i |=> core_reg_rdata_o == 16'h0000) // see [RULE12]
        else $error("register readable without core read");
    COV_WRITE: cover property (@(posedge mclk_i) disable iff (reset_i)
        mem_req_o && mem_we_o);
    COV_READ: cover property (@(posedge mclk_i) disable iff (reset_i)
        mem_req_o && !mem_we_o);
    COV_BOOT: cover property (@(posedge mclk_i) disable iff (reset_i)
        $fell(core_hold_o));
endmodule
`default_nettype wire

/* File: dv/host_model.sv */
// Purpose: host processor model that drives the multiplexed host port pins
// Assumes: strobes are active-high levels, sampled on the 200 MHz clock
// Notes:   a released bus shows the inverse of its last value, never a stale copy
`timescale 1ns/1ps
`default_nettype none
module host_model (
    input  wire logic        mclk_i,
    input  wire logic        ack_i,
    input  wire logic [15:0] bus_i,
    output logic             sel_o,
    output logic             ale_o,
    output logic             rd_o,
    output logic             wr_o,
    output logic      [15:0] bus_o
);
    int stalls = 0;

    initial begin
        sel_o = 1'b0;
        ale_o = 1'b0;
        rd_o  = 1'b0;
        wr_o  = 1'b0;
        bus_o = 16'h0000;
    end

    // bounded wait on the acknowledge level; a miss is counted, not hung on
    task automatic wait_ack(input logic lvl);
        int n;
        n = 0;
        while (ack_i !== lvl && n < 40) begin
            @(posedge mclk_i);
            n++;
        end
        if (n >= 40) stalls++;
    endtask

    task automatic latch(input logic [15:0] v);
        wait_ack(1'b1);
        sel_o <= 1'b1;
        ale_o <= 1'b1;
        bus_o <= v;
        repeat (4) @(posedge mclk_i);
        ale_o <= 1'b0;
        // keep select and bus up until the falling latch has passed the synchroniser
        repeat (4) @(posedge mclk_i);
        sel_o <= 1'b0;
        bus_o <= ~v;
        repeat (3) @(posedge mclk_i);
    endtask

    task automatic xfer(input logic we, input logic [15:0] wd,
                        output logic [15:0] rd, output int lat);
        wait_ack(1'b1);
        sel_o <= 1'b1;
        rd_o  <= ~we;
        wr_o  <= we;
        bus_o <= we ? wd : ~bus_o;
        lat = 0;
        do begin
            @(posedge mclk_i);
            lat++;
        end while (ack_i !== 1'b0 && lat < 10);
        wait_ack(1'b1);
        rd = bus_i;
        sel_o <= 1'b0;
        rd_o  <= 1'b0;
        wr_o  <= 1'b0;
        bus_o <= ~bus_o;
        repeat (3) @(posedge mclk_i);
    endtask
endmodule
`default_nettype wire

/* File: dv/testbench.sv */
// Purpose: self-checking bench for the host memory port
// Assumes: on-chip memory answers one cycle after a request
// Notes:   reference model keeps expected requests and memory contents
`timescale 1ns/1ps
`default_nettype none
`include "host_port_map.svh"
`define CHK(nm, e, g) begin n_tests++; if ((g) !== (e)) begin mismatches++; \
    $display("wrong value %s expected %h seen %h", nm, e, g); end end
module testbench;
    logic        mclk_i = 1'b0;
    logic        reset_i = 1'b1;
    logic [2:0]  boot_mode_i = 3'h5;
    logic        core_reg_we_i = 1'b0;
    logic        core_reg_re_i = 1'b0;
    logic [13:0] core_reg_addr_i = 14'h0000;
    logic [15:0] core_reg_wdata_i = 16'h0000;
    logic [23:0] mem_rdata_i = 24'h000000;
    logic        sel, ale, rd, wr, oe, ack, mem_req, mem_we, mem_memsel, core_hold;
    logic [15:0] hbus, dbus, bus_w, core_rdata;
    logic [13:0] mem_addr;
    logic [23:0] mem_wdata;
    logic [7:0]  ovl;
    logic [39:0] e;
    logic [39:0] exp_q[$];
    logic [23:0] ref_mem[int];
    logic [23:0] mem[int];
    int          idx;
    int          mismatches = 0;
    int          n_tests = 0;

    always #2.5 mclk_i = ~mclk_i;
    assign bus_w = (oe === 1'b1) ? dbus : hbus;

    host_memory_port u_dut (.mclk_i(mclk_i), .reset_i(reset_i), .port_select_i(sel),
        .address_latch_enable_i(ale), .host_read_strobe_i(rd), .host_write_strobe_i(wr),
        .host_addr_data_bus_i(bus_w), .host_addr_data_bus_o(dbus),
        .host_addr_data_bus_oe_o(oe), .host_acknowledge_o(ack), .boot_mode_i(boot_mode_i),
        .core_reg_we_i(core_reg_we_i), .core_reg_re_i(core_reg_re_i),
        .core_reg_addr_i(core_reg_addr_i), .core_reg_wdata_i(core_reg_wdata_i),
        .core_reg_rdata_o(core_rdata), .mem_req_o(mem_req), .mem_we_o(mem_we),
        .mem_memsel_o(mem_memsel), .mem_addr_o(mem_addr), .mem_wdata_o(mem_wdata),
        .mem_rdata_i(mem_rdata_i), .overlay_selection_o(ovl), .core_hold_o(core_hold));
    host_model u_host (.mclk_i(mclk_i), .ack_i(ack), .bus_i(bus_w), .sel_o(sel),
        .ale_o(ale), .rd_o(rd), .wr_o(wr), .bus_o(hbus));

    // ----------------------------------------------------------------
    // on-chip memory and request checker
    // ----------------------------------------------------------------
    always @(posedge mclk_i) begin
        if (mem_req === 1'b1) begin
            `CHK("request_expected", 1'b1, exp_q.size() != 0)
            e = (exp_q.size() != 0) ? exp_q.pop_front() : ~40'h0;
            `CHK("mem_we", e[39], mem_we)
            `CHK("mem_memsel", e[38], mem_memsel)
            `CHK("mem_addr", e[37:24], mem_addr)
            idx = int'({mem_memsel, mem_addr});
            if (e[39]) begin
                `CHK("mem_wdata", e[23:0], mem_wdata)
                mem[idx] = mem_wdata;
            end
            mem_rdata_i <= mem.exists(idx) ? mem[idx] : 24'h000000;
        end else begin
            // flip between requests so a late sample cannot pass
            mem_rdata_i <= ~mem_rdata_i;
        end
    end

    // ----------------------------------------------------------------
    // tasks
    // ----------------------------------------------------------------
    task automatic core_rd(output logic [15:0] v);
        core_reg_re_i   <= 1'b1;
        core_reg_addr_i <= `HP_CTRL_ADDR;
        @(posedge mclk_i);
        core_reg_re_i <= 1'b0;
        @(posedge mclk_i);
        v = core_rdata;
    endtask

    task automatic core_wr(input logic [15:0] v);
        core_reg_we_i    <= 1'b1;
        core_reg_addr_i  <= `HP_CTRL_ADDR;
        core_reg_wdata_i <= v;
        @(posedge mclk_i);
        core_reg_we_i <= 1'b0;
        @(posedge mclk_i);
    endtask

    // data memory stream from one latched start; writes carry random words
    task automatic stream(input int a, input int n, input logic we);
        logic [15:0] d, r;
        int          lat;
        u_host.latch({2'b00, 14'(a)});
        for (int i = 0; i < n; i++) begin
            d = 16'($urandom);
            if (!we) exp_q.push_back({2'b00, 14'(a + i), 24'h000000});
            else if (a + i < 'h3fe0) begin
                exp_q.push_back({2'b10, 14'(a + i), 8'h00, d});
                ref_mem[a + i] = {8'h00, d};
            end
            u_host.xfer(we, d, r, lat);
            `CHK("ack_latency", 1'b1, lat inside {[2:5]})
            if (!we) `CHK("read_data", ref_mem[a + i][15:0], r)
        end
    endtask

    task automatic pm_write(input int a, input logic [23:0] w);
        logic [15:0] r;
        int          lat;
        u_host.latch({2'b01, 14'(a)});
        u_host.xfer(1'b1, w[23:8], r, lat);
        exp_q.push_back({2'b11, 14'(a), w});
        u_host.xfer(1'b1, {8'h00, w[7:0]}, r, lat);
    endtask

    task automatic end_test(input string nm);
        `CHK("requests_left", 0, exp_q.size())
        $display("test %s done", nm);
    endtask

    task automatic summarize();
        `CHK("host_stalls", 0, u_host.stalls)
        $display("comparisons %0d mismatches %0d", n_tests, mismatches);
        if (mismatches == 0 && n_tests > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask

    initial begin
        repeat (20000) @(posedge mclk_i);
        mismatches++;
        $display("watchdog expired");
        summarize();
    end

    // ----------------------------------------------------------------
    // main sequence
    // ----------------------------------------------------------------
    initial begin
        logic [15:0] v;
        logic [7:0]  ov;
        logic [23:0] w;
        int          a, lat;
        void'($urandom(32'ha73a28a7));
        repeat (6) @(posedge mclk_i);
        reset_i <= 1'b0;
        repeat (5) @(posedge mclk_i);
        `CHK("ack_idle", 1'b1, ack)
        `CHK("bus_oe_idle", 1'b0, oe)
        `CHK("boot_hold", 1'b1, core_hold)
        core_rd(v);
        `CHK("ctrl_reset", `HP_CTRL_RESET, v)
        end_test("reset");
        a = $urandom_range(16'h3f00, 0);
        stream(a, 4, 1'b1);
        `CHK("boot_hold_dm", 1'b1, core_hold)
        stream(a, 4, 1'b0);
        end_test("dm_burst");
        stream('h3fde, 4, 1'b1);
        core_rd(v);
        `CHK("ctrl_after_guard", 16'h3fe2, v)
        end_test("mmr_guard");
        core_wr(16'(a + 1));
        exp_q.push_back({2'b00, 14'(a + 1), 24'h000000});
        u_host.xfer(1'b0, 16'h0000, v, lat);
        `CHK("core_set_start", ref_mem[a + 1][15:0], v)
        end_test("core_start");
        for (int i = 0; i < 3; i++) begin
            ov = 8'($urandom);
            u_host.latch({1'b1, 7'h00, ov});
            `CHK("overlay", ov, ovl)
        end
        end_test("overlay");
        w = 24'($urandom);
        pm_write(5, w);
        `CHK("boot_hold_pm", 1'b1, core_hold)
        // program word reads come back upper 16 bits first, then the low byte
        u_host.latch({2'b01, 14'h0005});
        repeat (2) exp_q.push_back({2'b01, 14'h0005, 24'h000000});
        u_host.xfer(1'b0, 16'h0000, v, lat);
        `CHK("pm_read_upper", w[23:8], v)
        u_host.xfer(1'b0, 16'h0000, v, lat);
        `CHK("pm_read_lower", {8'h00, w[7:0]}, v)
        pm_write(0, 24'($urandom));
        `CHK("boot_release", 1'b0, core_hold)
        end_test("pm_boot");
        boot_mode_i <= 3'h0;
        reset_i     <= 1'b1;
        repeat (2) @(posedge mclk_i);
        reset_i <= 1'b0;
        repeat (5) @(posedge mclk_i);
        `CHK("no_boot_hold", 1'b0, core_hold)
        stream(7, 2, 1'b1);
        end_test("second_reset");
        summarize();
    end
endmodule
`default_nettype wire
